// file: hdl/pdfc_pkg.sv
// Constants and register map for the play transfer and FIFO control block.
// Assumes a single 250 MHz clock domain and an indirect 8-bit register index.
// ====================================================================
// Notes on behaviour
// - Masked terminal count keeps run bit set
// - Run bit starts transfers; cleared by reset, count
// - Each request moves burst value plus one transfers
// - Burst counter reloads while acknowledge is high
// - Burst length survives chip reset; host programs
// - Chip reset clears whole play mode register
// - Terminal count sets read-only flag, raises interrupt
// - Status bit zero clears and holds count flag
// - I/O mode disables request and count flag
// - Unsigned select inverts byte or word msb
// - Width bit selects words; I/O needs words
// - Sample format selects signing and packing
// - High-byte enable steers bytes on data port
// - Enable low empties FIFO, clears flags, blocks requests
// - Push while full sets overflow; status clears
// - Pop while empty sets underflow; same clearing
// - Fill flags at four, eight, twelve words
// - Room and available flags; room after reset
// - Capacity interrupt enable gates play threshold interrupt
// - Ready mode picks threshold for interrupt, request
// - Byte mode doubles thresholds, counted in bytes
// - Master reset bit low holds block reset
// - Enable bits gate play and error sources
package pdfc_pkg;
   // ====================================================================
   // Register indices
   localparam logic [7:0] PDFC_OFF_CTL = 8'h88;
   localparam logic [7:0] PDFC_OFF_BURST = 8'h89;
   localparam logic [7:0] PDFC_OFF_MODE = 8'h8a;
   localparam logic [7:0] PDFC_OFF_DATA = 8'h8b;
   localparam logic [7:0] PDFC_OFF_FES = 8'h8c;
   localparam logic [7:0] PDFC_OFF_IRQM = 8'h8d;
   localparam logic [7:0] PDFC_OFF_RDBK = 8'h8f;
   // ====================================================================
   // Field positions
   localparam int PDFC_CTL_RUN = 0;
   localparam int PDFC_CTL_MASK = 6;
   localparam int PDFC_MODE_TC = 5;
   localparam int PDFC_MODE_IO = 4;
   localparam int PDFC_MODE_UNS = 3;
   localparam int PDFC_MODE_W16 = 2;
   localparam int PDFC_FES_FE = 0;
   localparam int PDFC_IRQM_FIE = 3;
   localparam int PDFC_STAT_TC = 0;
   localparam int PDFC_STAT_ERR = 4;
   // ====================================================================
   // FIFO geometry and thresholds in words
   localparam int PDFC_DEPTH = 16;
   localparam logic [5:0] PDFC_TH_Q1 = 6'h04;
   localparam logic [5:0] PDFC_TH_Q2 = 6'h08;
   localparam logic [5:0] PDFC_TH_Q3 = 6'h0c;
   localparam logic [5:0] PDFC_ROOM_1 = 6'h01;
   localparam logic [5:0] PDFC_ROOM_75 = 6'h0d;
   localparam logic [5:0] PDFC_ROOM_50 = 6'h09;
   localparam logic [5:0] PDFC_ROOM_25 = 6'h05;
   localparam logic [5:0] PDFC_CAP_W = 6'h10;
   localparam logic [1:0] PDFC_FMT_LIN16 = 2'h1;
   localparam logic [15:0] PDFC_MSB_WORD = 16'h8000;
   localparam logic [15:0] PDFC_MSB_BYTES = 16'h8080;
   localparam logic [15:0] PDFC_RST_WORD = 16'h0000;
endpackage : pdfc_pkg

// file: hdl/pdfc_play_ctrl.sv
// Play transfer control, burst shaping, I/O sample port and 16-word play FIFO.
// Assumes the bus strobes and acknowledge are synchronous one-cycle writes per transfer
// and that the DSP drains the output buffer with a ready/valid handshake.
`timescale 1ns/1ps
module pdfc_play_ctrl (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic master_chip_reset_bit_in,
   // Indirect register and transfer bus
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic sbhe_n_in,
   output logic [15:0] reg_rdata_out,
   // Status register writes
   input wire logic status_wr_in,
   input wire logic [7:0] status_wdata_in,
   // Host transfer handshake
   input wire logic play_acknowledge_in,
   input wire logic tc_in,
   output logic play_request_out,
   // Interrupt enables and sources
   input wire logic play_fifo_irq_enable_in,
   input wire logic fifo_error_irq_enable_in,
   output logic play_irq_a_out,
   output logic fifo_error_irq_out,
   output logic fifo_ready_irq_out,
   // DSP side
   input wire logic dsp_ready_in,
   output logic dsp_valid_out,
   output logic [15:0] dsp_data_out
);
   import pdfc_pkg::*;

   // ====================================================================
   // State
   typedef struct packed {
      logic run;
      logic mask;
      logic tc_flag;
      logic io_sel;
      logic uns_sel;
      logic w16_sel;
      logic [1:0] fmt;
      logic tc_hold;
      logic fe;
      logic ovf;
      logic unf;
      logic err_hold;
      logic [3:0] irqm;
      logic [PDFC_DEPTH-1:0][15:0] mem;
      logic [3:0] wp;
      logic [3:0] rp;
      logic [4:0] cnt;
      logic pend;
      logic [7:0] pend_byte;
      logic [5:0] bcnt;
      logic req;
      logic [1:0][15:0] obuf;
      logic [1:0] onum;
      logic dval;
      logic [15:0] rdata;
      logic play_irq;
      logic err_irq;
      logic rdy_irq;
   } pdfc_state_s;

   pdfc_state_s state_reg;
   pdfc_state_s state_next;
   logic [5:0] burst_length_value_reg;
   logic xfer;
   logic host_wr;
   logic hit;
   logic push_full;
   logic [4:0] fill;

   // Fill level, in bytes when byte transfers are selected
   function automatic logic [5:0] pdfc_level(input logic [4:0] cnt, input logic pend,
                                             input logic w16);
      pdfc_level = w16 ? {1'b0, cnt} : {cnt, pend};
   endfunction : pdfc_level

   // Threshold selected by the ready mode field
   function automatic logic pdfc_ready_hit(input logic [2:0] sel, input logic [5:0] lvl,
                                           input logic w16);
      logic [5:0] cap;
      logic [5:0] room;
      logic [5:0] th;
      cap = w16 ? PDFC_CAP_W : {PDFC_CAP_W[4:0], 1'b0};
      room = cap - lvl;
      case (sel)
         3'h0: th = PDFC_ROOM_1;
         3'h1: th = PDFC_ROOM_75;
         3'h2: th = PDFC_ROOM_50;
         3'h3: th = PDFC_ROOM_25;
         3'h4: th = PDFC_ROOM_1;
         3'h5: th = PDFC_TH_Q1;
         3'h6: th = PDFC_TH_Q2;
         default: th = PDFC_TH_Q3;
      endcase
      if (!w16) begin
         th = {th[4:0], 1'b0};
      end
      pdfc_ready_hit = sel[2] ? (lvl >= th) : (room >= th);
   endfunction : pdfc_ready_hit

   assign host_wr = reg_wr_in && play_acknowledge_in;
   assign xfer = reg_wr_in && !play_acknowledge_in;
   // Occupancy counts the output buffer too, so flags and full see every word held
   assign fill = state_reg.cnt + {3'h0, state_reg.onum};
   assign hit = pdfc_ready_hit(state_reg.irqm[2:0],
                               pdfc_level(fill, state_reg.pend, state_reg.w16_sel),
                               state_reg.w16_sel);
   assign push_full = fill == PDFC_CAP_W[4:0];

   // ====================================================================
   // Next state
   always_comb begin
      logic word_ok;
      logic [15:0] word;
      logic push;
      logic pop;
      logic take;
      logic [1:0] keep;
      word_ok = 1'b0;
      word = PDFC_RST_WORD;
      push = 1'b0;
      pop = 1'b0;
      take = 1'b0;
      keep = 2'h0;
      state_next = state_reg;

      // Register writes
      if (host_wr && reg_addr_in == PDFC_OFF_CTL) begin
         state_next.run = reg_wdata_in[PDFC_CTL_RUN];
         state_next.mask = reg_wdata_in[PDFC_CTL_MASK];
      end else if (host_wr && reg_addr_in == PDFC_OFF_MODE) begin
         state_next.io_sel = reg_wdata_in[PDFC_MODE_IO];
         state_next.uns_sel = reg_wdata_in[PDFC_MODE_UNS];
         state_next.w16_sel = reg_wdata_in[PDFC_MODE_W16];
         state_next.fmt = reg_wdata_in[1:0];
      end else if (host_wr && reg_addr_in == PDFC_OFF_FES) begin
         state_next.fe = reg_wdata_in[PDFC_FES_FE];
      end else if (host_wr && reg_addr_in == PDFC_OFF_IRQM) begin
         state_next.irqm = reg_wdata_in[3:0];
      end

      // Sample intake: I/O port steered by high-byte enable, or host transfer
      if (host_wr && reg_addr_in == PDFC_OFF_DATA && state_reg.io_sel) begin
         if (!sbhe_n_in) begin
            word_ok = 1'b1;
            word = reg_wdata_in;
         end else if (!state_reg.pend) begin
            state_next.pend = 1'b1;
            state_next.pend_byte = reg_wdata_in[7:0];
         end else begin
            word_ok = 1'b1;
            state_next.pend = 1'b0;
            word = {reg_wdata_in[7:0], state_reg.pend_byte};
         end
      end else if (xfer && !state_reg.io_sel) begin
         if (state_reg.w16_sel) begin
            word_ok = 1'b1;
            word = reg_wdata_in;
         end else if (!state_reg.pend) begin
            state_next.pend = 1'b1;
            state_next.pend_byte = reg_wdata_in[7:0];
         end else begin
            word_ok = 1'b1;
            state_next.pend = 1'b0;
            word = {reg_wdata_in[7:0], state_reg.pend_byte};
         end
      end
      if (state_reg.uns_sel) begin
         word = word ^ (state_reg.fmt == PDFC_FMT_LIN16 ? PDFC_MSB_WORD : PDFC_MSB_BYTES);
      end

      // Status register clears and holds; sets below use the old hold so a set wins
      if (status_wr_in) begin
         state_next.tc_hold = status_wdata_in[PDFC_STAT_TC];
         state_next.err_hold = status_wdata_in[PDFC_STAT_ERR];
         if (status_wdata_in[PDFC_STAT_TC]) begin
            state_next.tc_flag = 1'b0;
         end
         if (status_wdata_in[PDFC_STAT_ERR]) begin
            state_next.ovf = 1'b0;
            state_next.unf = 1'b0;
         end
      end

      // Terminal count
      if (xfer && tc_in && !state_reg.io_sel) begin
         if (!state_reg.mask) begin
            state_next.run = 1'b0;
         end
         if (!state_reg.tc_hold) begin
            state_next.tc_flag = 1'b1;
         end
      end

      // FIFO push and overflow
      if (word_ok && state_reg.fe) begin
         if (push_full) begin
            if (!state_reg.err_hold) begin
               state_next.ovf = 1'b1;
            end
         end else begin
            push = 1'b1;
            state_next.mem[state_reg.wp] = word;
            state_next.wp = state_reg.wp + 4'h1;
         end
      end

      // Output buffer: DSP takes the head, FIFO refills behind it
      take = dsp_ready_in && state_reg.onum != 2'h0;
      if (dsp_ready_in && state_reg.onum == 2'h0 && state_reg.fe && !state_reg.err_hold) begin
         state_next.unf = 1'b1;
      end
      keep = state_reg.onum - {1'b0, take};
      if (take) begin
         state_next.obuf[0] = state_reg.obuf[1];
      end
      pop = state_reg.cnt != 5'h00 && keep != 2'h2;
      if (pop) begin
         state_next.obuf[keep[0]] = state_reg.mem[state_reg.rp];
         state_next.rp = state_reg.rp + 4'h1;
      end
      state_next.onum = keep + {1'b0, pop};
      state_next.cnt = state_reg.cnt + {4'h0, push} - {4'h0, pop};

      // Burst counter and request
      if (play_acknowledge_in) begin
         state_next.bcnt = burst_length_value_reg;
      end else if (xfer && state_reg.bcnt != 6'h00) begin
         state_next.bcnt = state_reg.bcnt - 6'h01;
      end
      if (!state_reg.run || !state_reg.fe || state_reg.io_sel) begin
         state_next.req = 1'b0;
      end else if (state_reg.req) begin
         state_next.req = !(xfer && state_reg.bcnt == 6'h00);
      end else begin
         state_next.req = hit && play_acknowledge_in;
      end

      // Interrupt sources
      state_next.rdy_irq = hit && state_reg.io_sel && state_reg.fe;
      state_next.play_irq = play_fifo_irq_enable_in
         && ((state_reg.irqm[PDFC_IRQM_FIE] && hit && state_reg.fe) || state_reg.tc_flag);
      state_next.err_irq = fifo_error_irq_enable_in && (state_reg.ovf || state_reg.unf);

      // Read back
      state_next.rdata = PDFC_RST_WORD;
      if (reg_rd_in) begin
         if (reg_addr_in == PDFC_OFF_CTL) begin
            state_next.rdata = {9'h000, state_reg.mask, 5'h00, state_reg.run};
         end else if (reg_addr_in == PDFC_OFF_BURST) begin
            state_next.rdata = {10'h000, burst_length_value_reg};
         end else if (reg_addr_in == PDFC_OFF_MODE) begin
            state_next.rdata = {10'h000, state_reg.tc_flag, state_reg.io_sel,
                                state_reg.uns_sel, state_reg.w16_sel, state_reg.fmt};
         end else if (reg_addr_in == PDFC_OFF_FES) begin
            state_next.rdata = {8'h00, fill != 5'h00, !push_full,
                                {1'b0, fill} >= PDFC_TH_Q3,
                                {1'b0, fill} >= PDFC_TH_Q2,
                                {1'b0, fill} >= PDFC_TH_Q1,
                                state_reg.unf, state_reg.ovf, state_reg.fe};
         end else if (reg_addr_in == PDFC_OFF_IRQM) begin
            state_next.rdata = {12'h000, state_reg.irqm};
         end else if (reg_addr_in == PDFC_OFF_RDBK) begin
            state_next.rdata = state_reg.mem[state_reg.rp];
         end
      end

      // FIFO enable low holds the FIFO empty
      if (!state_reg.fe) begin
         state_next.cnt = 5'h00;
         state_next.wp = 4'h0;
         state_next.rp = 4'h0;
         state_next.onum = 2'h0;
         state_next.pend = 1'b0;
         state_next.ovf = 1'b0;
         state_next.unf = 1'b0;
         state_next.req = 1'b0;
      end
      state_next.dval = state_next.onum != 2'h0;

      // Master reset bit low holds all state cleared; burst length is kept
      if (!master_chip_reset_bit_in) begin
         state_next = '0;
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Burst length is kept across every reset
   always_ff @(posedge mclk_in) begin
      if (reg_wr_in && play_acknowledge_in && reg_addr_in == PDFC_OFF_BURST) begin
         burst_length_value_reg <= reg_wdata_in[5:0];
      end
   end

   assign reg_rdata_out = state_reg.rdata;
   assign play_request_out = state_reg.req;
   assign play_irq_a_out = state_reg.play_irq;
   assign fifo_error_irq_out = state_reg.err_irq;
   assign fifo_ready_irq_out = state_reg.rdy_irq;
   assign dsp_valid_out = state_reg.dval;
   assign dsp_data_out = state_reg.obuf[0];

   // ====================================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   property p_tc_clears_run;
      master_chip_reset_bit_in && xfer && tc_in && !state_reg.mask && !state_reg.io_sel
         |=> !state_reg.run;
   endproperty
   a_tc_clears_run: assert property (p_tc_clears_run) else $error("run kept after count");

   property p_mask_keeps_run;
      master_chip_reset_bit_in && state_reg.run && state_reg.mask && state_reg.fe
         && xfer && tc_in |=> state_reg.run;
   endproperty
   a_mask_keeps_run: assert property (p_mask_keeps_run) else $error("masked count cleared run");

   property p_mcr_clears;
      !master_chip_reset_bit_in |=> !state_reg.run && !state_reg.fe && state_reg.fmt == 2'h0
         && !state_reg.io_sel && !state_reg.w16_sel && !state_reg.tc_flag;
   endproperty
   a_mcr_clears: assert property (p_mcr_clears) else $error("chip reset left state");

   property p_burst_reload;
      master_chip_reset_bit_in && play_acknowledge_in
         |=> state_reg.bcnt == $past(burst_length_value_reg);
   endproperty
   a_burst_reload: assert property (p_burst_reload) else $error("burst not reloaded");

   property p_req_drop;
      state_reg.req && xfer && state_reg.bcnt == 6'h00 |=> !play_request_out;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request held past burst");

   property p_io_noreq;
      state_reg.io_sel |=> !play_request_out;
   endproperty
   a_io_noreq: assert property (p_io_noreq) else $error("request in io mode");

   property p_fe_empty;
      !state_reg.fe |=> state_reg.cnt == 5'h00 && !state_reg.ovf && !state_reg.unf
         && !dsp_valid_out;
   endproperty
   a_fe_empty: assert property (p_fe_empty) else $error("fifo not held empty");

   property p_ovf_set;
      master_chip_reset_bit_in && state_reg.fe && !state_reg.err_hold && push_full
         && host_wr && reg_addr_in == PDFC_OFF_DATA && state_reg.io_sel && !sbhe_n_in
         |=> state_reg.ovf;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

   property p_unf_set;
      master_chip_reset_bit_in && state_reg.fe && !state_reg.err_hold && dsp_ready_in
         && !dsp_valid_out |=> state_reg.unf;
   endproperty
   a_unf_set: assert property (p_unf_set) else $error("underflow missed");

   property p_tc_hold;
      state_reg.tc_hold && !status_wr_in |=> !state_reg.tc_flag [*2];
   endproperty
   a_tc_hold: assert property (p_tc_hold) else $error("count flag set while held");

   c_burst_done: cover property (state_reg.req && xfer && state_reg.bcnt == 6'h00);
   c_overflow: cover property ($rose(state_reg.ovf));
   c_tc_flag: cover property ($rose(state_reg.tc_flag));
   c_dsp_take: cover property (dsp_valid_out && dsp_ready_in ##1 dsp_valid_out);
endmodule : pdfc_play_ctrl

// file: test/pdfc_dma_model.sv
// Behavioural system DMA controller for the play channel of the transfer block.
// Assumes one transfer per clock while acknowledge is low and a level request.
`timescale 1ns/1ps
module pdfc_dma_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Bench control
   input wire logic enable_in,
   input wire logic tc_last_in,
   input wire logic [3:0] wait_in,
   input wire logic [5:0] burst_in,
   // Device handshake
   input wire logic play_request_in,
   output logic play_acknowledge_out,
   output logic wr_out,
   output logic tc_out,
   output logic [15:0] wdata_out,
   output logic done_out
);
   logic busy_reg;
   logic [3:0] dly_reg;
   logic [6:0] cnt_reg;
   logic [15:0] word_reg;
   // ====================================================================
   // Burst engine: idle, optional stall, burst_in+1 transfers, release
   always @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         busy_reg <= 1'b0;
         dly_reg <= 4'h0;
         cnt_reg <= 7'h00;
         word_reg <= 16'h0a00;
         play_acknowledge_out <= 1'b1;
         wr_out <= 1'b0;
         tc_out <= 1'b0;
         wdata_out <= 16'h5a5a;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (!busy_reg) begin
            play_acknowledge_out <= 1'b1;
            wr_out <= 1'b0;
            tc_out <= 1'b0;
            // Released lines toggle so no stale word looks valid
            wdata_out <= ~wdata_out;
            if (enable_in && play_request_in) begin
               busy_reg <= 1'b1;
               cnt_reg <= 7'h00;
               dly_reg <= wait_in;
            end
         end else if (dly_reg != 4'h0) begin
            dly_reg <= dly_reg - 4'h1;
         end else if (cnt_reg <= {1'b0, burst_in}) begin
            play_acknowledge_out <= 1'b0;
            wr_out <= 1'b1;
            wdata_out <= word_reg;
            word_reg <= word_reg + 16'h0001;
            tc_out <= tc_last_in && (cnt_reg == {1'b0, burst_in});
            cnt_reg <= cnt_reg + 7'h01;
         end else begin
            play_acknowledge_out <= 1'b1;
            wr_out <= 1'b0;
            tc_out <= 1'b0;
            wdata_out <= ~wdata_out;
            busy_reg <= 1'b0;
            done_out <= 1'b1;
         end
      end
   end
endmodule : pdfc_dma_model

// file: test/testbench.sv
// Self-checking bench for the play transfer and FIFO control block.
// Assumes the DMA model shares the write strobe and data lines with the bench.
`timescale 1ns/1ps
module testbench;
   import pdfc_pkg::*;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic master_chip_reset_bit = 1'b1;
   logic [7:0] addr = 8'h00;
   logic b_wr = 1'b0;
   logic b_rd = 1'b0;
   logic [15:0] b_wdata = 16'h0000;
   logic sbhe_n = 1'b0;
   logic st_wr = 1'b0;
   logic [7:0] st_wdata = 8'h00;
   logic dsp_rdy = 1'b0;
   logic play_fifo_irq_enable = 1'b1;
   logic foie = 1'b1;
   logic m_en = 1'b0;
   logic m_tc_last = 1'b0;
   logic [3:0] m_wait = 4'h0;
   logic [5:0] m_burst = 6'h00;
   logic m_ack, m_wr, m_tc, m_done, req, pirq, eirq, rirq, dval;
   logic [15:0] m_wdata, rdata, ddata;
   int tests_run = 0;
   int n_mismatch = 0;
   int i;
   always #2 mclk_in = ~mclk_in;
   // ====================================================================
   // Design and DMA controller model
   pdfc_play_ctrl pdfc_play_ctrl_inst (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .master_chip_reset_bit_in(master_chip_reset_bit),
      .reg_addr_in(addr), .reg_wr_in(b_wr | m_wr), .reg_rd_in(b_rd),
      .reg_wdata_in(m_ack ? b_wdata : m_wdata), .sbhe_n_in(sbhe_n), .reg_rdata_out(rdata),
      .status_wr_in(st_wr), .status_wdata_in(st_wdata), .play_acknowledge_in(m_ack),
      .tc_in(m_tc), .play_request_out(req), .play_fifo_irq_enable_in(play_fifo_irq_enable),
      .fifo_error_irq_enable_in(foie), .play_irq_a_out(pirq), .fifo_error_irq_out(eirq),
      .fifo_ready_irq_out(rirq), .dsp_ready_in(dsp_rdy), .dsp_valid_out(dval),
      .dsp_data_out(ddata));
   pdfc_dma_model pdfc_dma_model_inst (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .enable_in(m_en), .tc_last_in(m_tc_last),
      .wait_in(m_wait), .burst_in(m_burst), .play_request_in(req),
      .play_acknowledge_out(m_ack), .wr_out(m_wr), .tc_out(m_tc), .wdata_out(m_wdata),
      .done_out(m_done));
   // ====================================================================
   // Access tasks
   task automatic summarize;
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge mclk_in);
      addr = a;
      b_wdata = d;
      b_wr = 1'b1;
      @(negedge mclk_in);
      b_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(negedge mclk_in);
      addr = a;
      b_rd = 1'b1;
      @(negedge mclk_in);
      b_rd = 1'b0;
      chk(rdata, exp);
   endtask : rd
   task automatic sw(input logic [7:0] d);
      @(negedge mclk_in);
      st_wdata = d;
      st_wr = 1'b1;
      @(negedge mclk_in);
      st_wr = 1'b0;
   endtask : sw
   task automatic pop(input logic [15:0] exp);
      @(negedge mclk_in);
      chk({15'h0000, dval}, 16'h0001);
      chk(ddata, exp);
      dsp_rdy = 1'b1;
      @(negedge mclk_in);
      dsp_rdy = 1'b0;
   endtask : pop
   task automatic burst;
      int k;
      m_en = 1'b1;
      for (k = 0; k < 200 && m_done !== 1'b1; k++)
         @(negedge mclk_in);
      m_en = 1'b0;
      if (k == 200) begin
         n_mismatch++;
         summarize();
      end
   endtask : burst
   // ====================================================================
   // Main sequence
   initial begin
      repeat (14) @(negedge mclk_in);
      // Burst length has no reset, so it is loaded before release
      wr(PDFC_OFF_BURST, 16'h0003);
      sys_rst_in = 1'b0;
      rd(PDFC_OFF_CTL, 16'h0000);
      rd(PDFC_OFF_MODE, 16'h0000);
      rd(PDFC_OFF_FES, 16'h0040);
      rd(PDFC_OFF_IRQM, 16'h0000);
      rd(8'h8e, 16'h0000);
      wr(PDFC_OFF_MODE, 16'h0015);
      wr(PDFC_OFF_FES, 16'h0001);
      wr(PDFC_OFF_CTL, 16'h0001);
      rd(PDFC_OFF_IRQM, 16'h0000);
      chk({15'h0000, req}, 16'h0000);
      chk({15'h0000, rirq}, 16'h0001);
      for (i = 0; i < 4; i++) wr(PDFC_OFF_DATA, 16'h1000 + 16'(i));
      rd(PDFC_OFF_FES, 16'h00c9);
      sbhe_n = 1'b1;
      wr(PDFC_OFF_DATA, 16'h1234);
      wr(PDFC_OFF_DATA, 16'h1212);
      sbhe_n = 1'b0;
      for (i = 0; i < 11; i++) wr(PDFC_OFF_DATA, 16'h2000 + 16'(i));
      rd(PDFC_OFF_FES, 16'h00b9);
      chk({15'h0000, rirq}, 16'h0000);
      wr(PDFC_OFF_DATA, 16'hdead);
      rd(PDFC_OFF_FES, 16'h00bb);
      chk({15'h0000, eirq}, 16'h0001);
      foie = 1'b0;
      @(negedge mclk_in);
      chk({15'h0000, eirq}, 16'h0000);
      foie = 1'b1;
      sw(8'h10);
      rd(PDFC_OFF_FES, 16'h00b9);
      sw(8'h00);
      for (i = 0; i < 4; i++) pop(16'h1000 + 16'(i));
      pop(16'h1234);
      for (i = 0; i < 11; i++) pop(16'h2000 + 16'(i));
      rd(PDFC_OFF_FES, 16'h0041);
      chk({15'h0000, rirq}, 16'h0001);
      @(negedge mclk_in);
      dsp_rdy = 1'b1;
      @(negedge mclk_in);
      dsp_rdy = 1'b0;
      rd(PDFC_OFF_FES, 16'h0045);
      chk({15'h0000, eirq}, 16'h0001);
      sw(8'h10);
      sw(8'h00);
      rd(PDFC_OFF_FES, 16'h0041);
      chk({15'h0000, eirq}, 16'h0000);
      wr(PDFC_OFF_IRQM, 16'h0004);
      wr(PDFC_OFF_MODE, 16'h001d);
      rd(PDFC_OFF_FES, 16'h0041);
      chk({15'h0000, rirq}, 16'h0000);
      wr(PDFC_OFF_DATA, 16'h1234);
      rd(PDFC_OFF_FES, 16'h00c1);
      chk({15'h0000, rirq}, 16'h0001);
      pop(16'h9234);
      // DMA burst with terminal count, mask clear
      wr(PDFC_OFF_CTL, 16'h0000);
      wr(PDFC_OFF_FES, 16'h0000);
      wr(PDFC_OFF_MODE, 16'h0005);
      wr(PDFC_OFF_BURST, 16'h0003);
      wr(PDFC_OFF_IRQM, 16'h0000);
      wr(PDFC_OFF_FES, 16'h0001);
      m_burst = 6'h03;
      m_wait = 4'h3;
      m_tc_last = 1'b1;
      wr(PDFC_OFF_CTL, 16'h0001);
      burst();
      chk({15'h0000, req}, 16'h0000);
      rd(PDFC_OFF_CTL, 16'h0000);
      rd(PDFC_OFF_MODE, 16'h0025);
      chk({15'h0000, pirq}, 16'h0001);
      play_fifo_irq_enable = 1'b0;
      @(negedge mclk_in);
      chk({15'h0000, pirq}, 16'h0000);
      play_fifo_irq_enable = 1'b1;
      rd(PDFC_OFF_FES, 16'h00c9);
      sw(8'h01);
      rd(PDFC_OFF_MODE, 16'h0005);
      chk({15'h0000, pirq}, 16'h0000);
      sw(8'h00);
      // Single transfer with terminal count masked
      m_burst = 6'h00;
      m_wait = 4'h0;
      wr(PDFC_OFF_BURST, 16'h0000);
      wr(PDFC_OFF_CTL, 16'h0041);
      burst();
      rd(PDFC_OFF_CTL, 16'h0041);
      rd(PDFC_OFF_MODE, 16'h0025);
      wr(PDFC_OFF_CTL, 16'h0000);
      for (i = 0; i < 5; i++) pop(16'h0a00 + 16'(i));
      // Byte transfers: two bytes pack into one word, low byte first
      wr(PDFC_OFF_MODE, 16'h0000);
      wr(PDFC_OFF_BURST, 16'h0001);
      wr(PDFC_OFF_IRQM, 16'h0001);
      m_burst = 6'h01;
      m_tc_last = 1'b0;
      wr(PDFC_OFF_CTL, 16'h0001);
      burst();
      wr(PDFC_OFF_CTL, 16'h0000);
      pop(16'h0605);
      // Master chip reset
      wr(PDFC_OFF_BURST, 16'h002a);
      wr(PDFC_OFF_IRQM, 16'h000b);
      rd(PDFC_OFF_IRQM, 16'h000b);
      master_chip_reset_bit = 1'b0;
      repeat (2) @(negedge mclk_in);
      master_chip_reset_bit = 1'b1;
      rd(PDFC_OFF_CTL, 16'h0000);
      rd(PDFC_OFF_MODE, 16'h0000);
      rd(PDFC_OFF_FES, 16'h0040);
      rd(PDFC_OFF_IRQM, 16'h0000);
      rd(PDFC_OFF_BURST, 16'h002a);
      summarize();
   end
endmodule : testbench
